//--- verilog/sspx_pkg.sv
// Purpose: shared constants for the stack and stack-pointer load executor
// Assumes: byte-wide memory, one clock state per CLOCK cycle
// Notes: opcodes, field positions, state counts and reset values
package sspx_pkg;

  // ----------------------------------------
  // Opcodes and prefixes
  // ----------------------------------------
  localparam logic [7:0] OP_PREFIX_FIRST = 8'hDD;
  localparam logic [7:0] OP_PREFIX_SECOND = 8'hFD;
  localparam logic [7:0] OP_STORE_ABS = 8'h22;
  localparam logic [7:0] OP_LOAD_SP = 8'hF9;
  localparam logic [7:0] OP_PUSH_INDEX = 8'hE5;
  localparam logic [7:0] OP_POP_INDEX = 8'hE1;
  localparam logic [7:0] OP_PAIR_MASK = 8'hCF;
  localparam logic [7:0] OP_PUSH_PAIR = 8'hC5;
  localparam logic [7:0] OP_POP_PAIR = 8'hC1;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int PAIR_SEL_LSB = 4;
  localparam logic [1:0] SEL_COUNTER = 2'h0;
  localparam logic [1:0] SEL_TARGET = 2'h1;
  localparam logic [1:0] SEL_POINTER = 2'h2;
  localparam logic [1:0] SEL_ACC_FLAGS = 2'h3;

  // ----------------------------------------
  // Clock states per machine cycle
  // ----------------------------------------
  localparam logic [2:0] T_FETCH = 3'h4;
  localparam logic [2:0] T_MEM = 3'h3;
  localparam logic [2:0] T_LONG = 3'h5;
  localparam logic [2:0] T_SP_LOAD = 3'h6;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_SP = 16'hFFFF;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_OPCODE = 4'h1,
    ST_ADDR_LO = 4'h2,
    ST_ADDR_HI = 4'h3,
    ST_WR_LO = 4'h4,
    ST_WR_HI = 4'h5,
    ST_SP_COPY = 4'h6,
    ST_PUSH_HI = 4'h7,
    ST_PUSH_LO = 4'h8,
    ST_POP_LO = 4'h9,
    ST_POP_HI = 4'hA,
    ST_PREP = 4'hB
  } sspx_state_t;

endpackage : sspx_pkg

//--- verilog/sspx_tcount.sv
// Purpose: counts clock states inside one machine cycle
// Assumes: load pulses on the first state of each machine cycle
// Notes: done is high in the last state of the cycle
`timescale 1ns/100ps
module sspx_tcount
  import sspx_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control
  input wire logic load,
  input wire logic [2:0] length,
  output logic done
);

  logic [2:0] left;
  logic [2:0] next_left;

  always_comb begin
    next_left = left;
    if (load) begin
      next_left = length - 3'h1;
    end else if (left != 3'h0) begin
      next_left = left - 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      left <= 3'h0;
    end else begin
      left <= next_left;
    end
  end

  // A one-state cycle would finish on its load state
  assign done = load ? (length == 3'h1) : (left == 3'h1);

endmodule : sspx_tcount

//--- verilog/sspx_regs.sv
// Purpose: register pairs, index registers and stack pointer for the executor
// Assumes: at most one write per pair per cycle
// Notes: flags byte is only written by a pop of the accumulator-flags pair
`timescale 1ns/100ps
module sspx_regs
  import sspx_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Write port, byte granular
  input wire logic [2:0] wr_sel,
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire logic [7:0] wr_byte,
  // Stack pointer update
  input wire logic sp_load,
  input wire logic [15:0] sp_value,
  // Contents
  output logic [15:0] pair_q [0:5],
  output logic [15:0] sp_q
);

  // Index 0..3 follow the pair select field, 4 and 5 are the index registers
  logic [15:0] next_pair [0:5];
  logic [15:0] next_sp;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      next_pair[i] = pair_q[i];
      if (wr_sel == 3'(i)) begin
        if (wr_hi) begin
          next_pair[i][15:8] = wr_byte;
        end
        if (wr_lo) begin
          next_pair[i][7:0] = wr_byte;
        end
      end
    end
    next_sp = sp_load ? sp_value : sp_q;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < 6; i++) begin
        pair_q[i] <= RST_WORD;
      end
      sp_q <= RST_SP;
    end else begin
      pair_q <= next_pair;
      sp_q <= next_sp;
    end
  end

endmodule : sspx_regs

//--- verilog/sspx_exec.sv
// Purpose: fetch and execute 16-bit store, stack-pointer load, push and pop
// Assumes: external memory answers a read in the same clock state (comb data)
// Notes: one CLOCK cycle per clock state; unknown opcodes are skipped
//
// How it works
// - DD 22 nn writes first index low byte to nn, high to nn+1.
// - FD 22 nn writes second index low byte to nn, high to nn+1.
// - First operand byte after opcode is address low, second is high.
// - Index store runs 6 machine cycles, 20 states: 4,4,3,3,3,3.
// - F9 copies pointer pair to stack pointer in one 6-state cycle.
// - DD F9 copies first index to stack pointer, states 4 then 6.
// - FD F9 copies second index to stack pointer, states 4 then 6.
// - Bits 5:4 pick counter, target, pointer or accumulator-flags pair.
// - Pair push: decrement, write high, decrement, write low; 5,3,3.
// - DD/FD E5 push index high then low, states 4,5,3,3.
// - Pair pop reads low then high, incrementing twice; states 4,3,3.
// - DD E1 pops first index low then high; 14 states, two increments.
// - Second index pop fills low then high; states 4,4,3,3.
// - Stack pointer is 16 bits, stack grows toward lower addresses.
`timescale 1ns/100ps
module sspx_exec
  import sspx_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // Memory port
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  // Status
  output logic INSTR_DONE,
  output logic [15:0] STACK_POINTER,
  output logic [15:0] COUNTER_PAIR,
  output logic [15:0] TARGET_PAIR,
  output logic [15:0] POINTER_PAIR,
  output logic [15:0] ACC_FLAGS_PAIR,
  output logic [15:0] FIRST_INDEX,
  output logic [15:0] SECOND_INDEX
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // Register file index of the pair named by the select field
  function automatic logic [2:0] pair_index(input logic [7:0] op);
    pair_index = {1'b0, op[PAIR_SEL_LSB+1:PAIR_SEL_LSB]};
  endfunction : pair_index

  function automatic logic is_prefix(input logic [7:0] op);
    is_prefix = (op == OP_PREFIX_FIRST) || (op == OP_PREFIX_SECOND);
  endfunction : is_prefix

  localparam logic [2:0] IDX_FIRST = 3'h4;
  localparam logic [2:0] IDX_SECOND = 3'h5;

  // ----------------------------------------
  // State
  // ----------------------------------------
  sspx_state_t state;
  sspx_state_t next_state;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic [2:0] sel;
  logic [2:0] next_sel;
  logic done_q;
  logic next_done;
  logic sel_prefixed;
  logic next_prefixed;

  logic [15:0] pair_q [0:5];
  logic [15:0] sp_q;
  logic [15:0] sel_word;

  logic t_load;
  logic [2:0] t_len;
  logic t_done;
  logic first_state;
  logic next_first;

  logic wr_hi;
  logic wr_lo;
  logic sp_load;
  logic [15:0] sp_value;
  logic [15:0] next_mem_addr;
  logic next_mem_rd;
  logic next_mem_wr;
  logic [7:0] next_mem_wdata;

  sspx_tcount u_tcount (
    .clock(CLOCK),
    .nrst(NRST),
    .load(t_load),
    .length(t_len),
    .done(t_done)
  );

  sspx_regs u_regs (
    .clock(CLOCK),
    .nrst(NRST),
    .wr_sel(sel),
    .wr_hi(wr_hi),
    .wr_lo(wr_lo),
    .wr_byte(MEM_RDATA),
    .sp_load(sp_load),
    .sp_value(sp_value),
    .pair_q(pair_q),
    .sp_q(sp_q)
  );

  assign sel_word = pair_q[sel];
  assign t_load = first_state;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Memory is read combinationally on the last state of a fetch or read
  // cycle; the address is held from flip-flops for the whole cycle.
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_addr = addr;
    next_sel = sel;
    next_done = 1'b0;
    next_first = 1'b0;
    t_len = T_MEM;
    wr_hi = 1'b0;
    wr_lo = 1'b0;
    sp_load = 1'b0;
    sp_value = sp_q;
    next_mem_addr = MEM_ADDR;
    next_mem_rd = MEM_RD;
    next_mem_wr = MEM_WR;
    next_mem_wdata = MEM_WDATA;
    case (state)
      ST_IDLE: begin
        next_state = ST_OPCODE;
        next_first = 1'b1;
        next_sel = IDX_FIRST;
        next_mem_addr = pc;
        next_mem_rd = 1'b1;
      end
      ST_OPCODE: begin
        t_len = T_FETCH;
        if (t_done) begin
          next_pc = pc + 16'h0001;
          next_first = 1'b1;
          next_mem_rd = 1'b0;
          next_state = ST_OPCODE;
          next_mem_addr = next_pc;
          if (is_prefix(MEM_RDATA)) begin
            next_sel = (MEM_RDATA == OP_PREFIX_FIRST) ? IDX_FIRST : IDX_SECOND;
            next_mem_rd = 1'b1;
          end else if (MEM_RDATA == OP_STORE_ABS && sel_prefixed) begin
            next_state = ST_ADDR_LO;
            next_mem_rd = 1'b1;
          end else if (MEM_RDATA == OP_LOAD_SP) begin
            // Unprefixed form works on the pointer pair
            if (!sel_prefixed) begin
              next_sel = {1'b0, SEL_POINTER};
            end
            next_state = ST_SP_COPY;
          end else if (MEM_RDATA == OP_PUSH_INDEX && sel_prefixed) begin
            next_state = ST_PREP;
          end else if (MEM_RDATA == OP_POP_INDEX && sel_prefixed) begin
            next_state = ST_POP_LO;
            next_mem_addr = sp_q;
            next_mem_rd = 1'b1;
          end else if ((MEM_RDATA & OP_PAIR_MASK) == OP_PUSH_PAIR && !sel_prefixed) begin
            next_sel = pair_index(MEM_RDATA);
            next_state = ST_PREP;
          end else if ((MEM_RDATA & OP_PAIR_MASK) == OP_POP_PAIR && !sel_prefixed) begin
            next_sel = pair_index(MEM_RDATA);
            next_state = ST_POP_LO;
            next_mem_addr = sp_q;
            next_mem_rd = 1'b1;
          end else begin
            next_state = ST_IDLE;
            next_first = 1'b0;
            next_done = 1'b1;
          end
        end
      end
      ST_ADDR_LO: begin
        if (t_done) begin
          next_addr = {addr[15:8], MEM_RDATA};
          next_pc = pc + 16'h0001;
          next_mem_addr = next_pc;
          next_first = 1'b1;
          next_state = ST_ADDR_HI;
        end
      end
      ST_ADDR_HI: begin
        if (t_done) begin
          next_addr = {MEM_RDATA, addr[7:0]};
          next_pc = pc + 16'h0001;
          next_mem_addr = {MEM_RDATA, addr[7:0]};
          next_mem_rd = 1'b0;
          next_mem_wr = 1'b1;
          next_mem_wdata = sel_word[7:0];
          next_first = 1'b1;
          next_state = ST_WR_LO;
        end
      end
      ST_WR_LO: begin
        if (t_done) begin
          next_mem_addr = addr + 16'h0001;
          next_mem_wdata = sel_word[15:8];
          next_first = 1'b1;
          next_state = ST_WR_HI;
        end
      end
      ST_SP_COPY: begin
        // The opcode fetch already ran four of the six states
        t_len = T_SP_LOAD - T_FETCH;
        if (t_done) begin
          sp_load = 1'b1;
          sp_value = sel_word;
          next_state = ST_IDLE;
          next_done = 1'b1;
        end
      end
      ST_PREP: begin
        // One internal state stretches the opcode fetch before any push writes
        t_len = T_LONG - T_FETCH;
        if (t_done) begin
          sp_load = 1'b1;
          sp_value = sp_q - 16'h0001;
          next_mem_addr = sp_q - 16'h0001;
          next_mem_wr = 1'b1;
          next_mem_wdata = sel_word[15:8];
          next_first = 1'b1;
          next_state = ST_PUSH_HI;
        end
      end
      ST_PUSH_HI: begin
        if (t_done) begin
          sp_load = 1'b1;
          sp_value = sp_q - 16'h0001;
          next_mem_addr = sp_q - 16'h0001;
          next_mem_wdata = sel_word[7:0];
          next_first = 1'b1;
          next_state = ST_PUSH_LO;
        end
      end
      ST_POP_LO: begin
        if (t_done) begin
          wr_lo = 1'b1;
          sp_load = 1'b1;
          sp_value = sp_q + 16'h0001;
          next_mem_addr = sp_q + 16'h0001;
          next_first = 1'b1;
          next_state = ST_POP_HI;
        end
      end
      ST_WR_HI, ST_PUSH_LO, ST_POP_HI: begin
        if (t_done) begin
          if (state == ST_POP_HI) begin
            wr_hi = 1'b1;
            sp_load = 1'b1;
            sp_value = sp_q + 16'h0001;
          end
          next_mem_rd = 1'b0;
          next_mem_wr = 1'b0;
          next_state = ST_IDLE;
          next_done = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Prefix seen: set by a prefix fetch, cleared when the instruction ends
  always_comb begin
    next_prefixed = sel_prefixed;
    if (state == ST_OPCODE && t_done && is_prefix(MEM_RDATA)) begin
      next_prefixed = 1'b1;
    end else if (next_state == ST_IDLE) begin
      next_prefixed = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state <= ST_IDLE;
      pc <= RST_WORD;
      addr <= RST_WORD;
      sel <= 3'h0;
      done_q <= 1'b0;
      first_state <= 1'b0;
      sel_prefixed <= 1'b0;
      MEM_ADDR <= RST_WORD;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_WDATA <= 8'h00;
    end else begin
      state <= next_state;
      pc <= next_pc;
      addr <= next_addr;
      sel <= next_sel;
      done_q <= next_done;
      first_state <= next_first;
      sel_prefixed <= next_prefixed;
      MEM_ADDR <= next_mem_addr;
      MEM_RD <= next_mem_rd;
      MEM_WR <= next_mem_wr;
      MEM_WDATA <= next_mem_wdata;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Flags byte only moves through a pop of the accumulator-flags pair
  assign INSTR_DONE = done_q;
  assign STACK_POINTER = sp_q;
  assign COUNTER_PAIR = pair_q[0];
  assign TARGET_PAIR = pair_q[1];
  assign POINTER_PAIR = pair_q[2];
  assign ACC_FLAGS_PAIR = pair_q[3];
  assign FIRST_INDEX = pair_q[4];
  assign SECOND_INDEX = pair_q[5];

endmodule : sspx_exec

//--- tb/sspx_chk.sv
// Purpose: port checker for the stack and stack-pointer load executor
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every sspx_exec instance at the foot of this file
`timescale 1ns/100ps
module sspx_chk
  import sspx_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // Memory port
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [7:0] MEM_WDATA,
  // Status
  input wire logic INSTR_DONE,
  input wire logic [15:0] STACK_POINTER,
  input wire logic [15:0] ACC_FLAGS_PAIR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // No instruction is shorter than a four-state fetch plus the idle cycle
  property p_done_gap;
    INSTR_DONE |=> !INSTR_DONE [*3];
  endproperty
  a_done_gap: assert property (p_done_gap) else $error("done pulses too close");
  property p_rd_wr_excl;
    !(MEM_RD && MEM_WR);
  endproperty
  a_rd_wr_excl: assert property (p_rd_wr_excl) else $error("read and write together");
  property p_rd_cycle;
    $rose(MEM_RD) |=> (MEM_RD && $stable(MEM_ADDR)) [*2];
  endproperty
  a_rd_cycle: assert property (p_rd_cycle) else $error("read cycle too short");
  property p_wr_cycle;
    $rose(MEM_WR) |=> (MEM_WR && $stable(MEM_ADDR) && $stable(MEM_WDATA)) [*2];
  endproperty
  a_wr_cycle: assert property (p_wr_cycle) else $error("write cycle too short");
  property p_reset_vals;
    $rose(NRST) |-> STACK_POINTER == RST_SP && !MEM_WR;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad state after reset");
  property p_first_fetch;
    $rose(NRST) |-> ##[1:2] (MEM_RD && MEM_ADDR == 16'h0000);
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("no fetch after reset");
  property p_next_fetch;
    INSTR_DONE |-> ##[0:2] MEM_RD;
  endproperty
  a_next_fetch: assert property (p_next_fetch) else $error("no fetch after done");
  // Flags may only move as a popped byte arrives
  property p_flags_kept;
    $changed(ACC_FLAGS_PAIR[7:0]) |-> $past(MEM_RD) || $past(MEM_RD, 2);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

  c_write: cover property ($rose(MEM_WR));
  c_sp_move: cover property ($changed(STACK_POINTER));
  c_done: cover property (INSTR_DONE);
endmodule : sspx_chk

bind sspx_exec sspx_chk u_chk (
  .CLOCK(CLOCK),
  .NRST(NRST),
  .MEM_ADDR(MEM_ADDR),
  .MEM_RD(MEM_RD),
  .MEM_WR(MEM_WR),
  .MEM_WDATA(MEM_WDATA),
  .INSTR_DONE(INSTR_DONE),
  .STACK_POINTER(STACK_POINTER),
  .ACC_FLAGS_PAIR(ACC_FLAGS_PAIR)
);

//--- tb/sspx_mem.sv
// Purpose: byte-wide external memory holding program and stack
// Assumes: combinational read, write on the clock edge
// Notes: an idle read bus shows the inverse of the last byte read
`timescale 1ns/100ps
module sspx_mem (
  // Clock
  input wire logic clock,
  // Bus
  input wire logic [15:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] m [0:65535];
  logic [7:0] last = 8'h5A;

  // Inverse keeps a stale byte from passing for a real answer
  assign rdata = rd ? m[addr] : ~last;

  always @(posedge clock) begin
    if (rd) begin
      last <= m[addr];
    end
    if (wr) begin
      m[addr] <= wdata;
    end
  end
endmodule : sspx_mem

//--- tb/sspx_exec_bench.sv
// Purpose: self-checking bench for the stack and stack-pointer load executor
// Assumes: done pulses are spaced by the instruction's states plus one idle
// Notes: three runs with fresh random stack data, reset between them
`timescale 1ns/100ps
module sspx_exec_bench;
  import sspx_pkg::*;
  logic CLOCK = 1'b0;
  logic NRST = 1'b0;
  logic [15:0] MEM_ADDR, STACK_POINTER, COUNTER_PAIR, TARGET_PAIR, POINTER_PAIR;
  logic [15:0] ACC_FLAGS_PAIR, FIRST_INDEX, SECOND_INDEX;
  logic MEM_RD, MEM_WR, INSTR_DONE;
  logic [7:0] MEM_WDATA, MEM_RDATA;
  int bad_count = 0;
  int compares = 0;
  logic [31:0] seed = 32'hCC34D869;
  logic [7:0] d [0:11];
  int states [0:20] = '{10, 6, 10, 10, 10, 10, 14, 14, 11, 11, 11, 11, 15, 15, 20, 20, 10,
    11, 10, 4, 8};
  // First pop wraps from FFFF to 0000, then the stack moves to E140
  // The tail is skipped: an unprefixed store opcode, then a prefixed pair push
  logic [7:0] prog [0:33] = '{8'hE1, 8'hF9, 8'hC1, 8'hD1, 8'hE1, 8'hF1, 8'hDD, 8'hE1,
    8'hFD, 8'hE1, 8'hC5, 8'hD5, 8'hE5, 8'hF5, 8'hDD, 8'hE5, 8'hFD, 8'hE5, 8'hDD, 8'h22,
    8'h00, 8'hC0, 8'hFD, 8'h22, 8'h00, 8'hC1, 8'hDD, 8'hF9, 8'hC5, 8'hFD, 8'hF9,
    8'h22, 8'hDD, 8'hC5};

  sspx_exec dut (.CLOCK(CLOCK), .NRST(NRST), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
    .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .INSTR_DONE(INSTR_DONE), .STACK_POINTER(STACK_POINTER), .COUNTER_PAIR(COUNTER_PAIR),
    .TARGET_PAIR(TARGET_PAIR), .POINTER_PAIR(POINTER_PAIR),
    .ACC_FLAGS_PAIR(ACC_FLAGS_PAIR), .FIRST_INDEX(FIRST_INDEX),
    .SECOND_INDEX(SECOND_INDEX));
  sspx_mem mem (.clock(CLOCK), .addr(MEM_ADDR), .rd(MEM_RD), .wr(MEM_WR),
    .wdata(MEM_WDATA), .rdata(MEM_RDATA));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test;
    $display("Checks %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  initial begin
    forever #2 CLOCK = ~CLOCK;
  end

  initial begin : main
    logic [15:0] ix, iy, nn, nn2;
    int n;
    for (int it = 0; it < 3; it++) begin
      @(posedge CLOCK);
      #1 NRST = 1'b0;
      for (int a = 0; a < 65536; a++) mem.m[a] = 8'h00;
      for (int i = 0; i < 12; i++) begin
        repeat (8) seed = lfsr(seed);
        d[i] = seed[7:0];
      end
      // Keep the index-based stack clear of program, stores and stack
      d[9] = {2'b10, d[9][5:0]};
      seed = lfsr(seed);
      // Even low byte keeps nn+1 off the second store's address
      nn = {8'hC0, seed[7:1], 1'b0};
      nn2 = {8'hC1, seed[15:8]};
      prog[20] = nn[7:0];
      prog[24] = nn2[7:0];
      for (int i = 0; i < 34; i++) mem.m[i] = prog[i];
      mem.m[16'hFFFF] = 8'h40;
      for (int i = 0; i < 12; i++) mem.m[16'hE140 + i] = d[i];
      repeat (16) @(posedge CLOCK);
      #1 NRST = 1'b1;
      for (int k = 0; k < 21; k++) begin
        n = 0;
        do begin
          @(posedge CLOCK);
          #1 n++;
        end while (INSTR_DONE !== 1'b1 && n < 100);
        if (n >= 100) begin
          bad_count++;
          $display("Error INSTR_DONE expected 1 seen timeout");
          break;
        end
        if (k > 0) check("instr states", 16'(states[k] + 1), 16'(n));
      end
      if (n >= 100) break;
      ix = {d[9], d[8]};
      iy = {d[11], d[10]};
      check("stack pointer", iy, STACK_POINTER);
      check("counter pair", {d[1], d[0]}, COUNTER_PAIR);
      check("target pair", {d[3], d[2]}, TARGET_PAIR);
      check("pointer pair", {d[5], d[4]}, POINTER_PAIR);
      check("acc flags pair", {d[7], d[6]}, ACC_FLAGS_PAIR);
      check("first index", ix, FIRST_INDEX);
      check("second index", iy, SECOND_INDEX);
      for (int k = 0; k < 6; k++) begin
        check("push high", {8'h00, d[2*k+1]}, {8'h00, mem.m[16'hE14B - 2*k]});
        check("push low", {8'h00, d[2*k]}, {8'h00, mem.m[16'hE14A - 2*k]});
      end
      check("store first", ix, {mem.m[nn + 16'h0001], mem.m[nn]});
      check("store second", iy, {mem.m[nn2 + 16'h0001], mem.m[nn2]});
      check("push at index", {d[1], d[0]}, {mem.m[ix - 16'h0001], mem.m[ix - 16'h0002]});
    end
    finish_test();
  end : main
endmodule : sspx_exec_bench
